// [design/slrf_status_lines.sv]
// Status-line direction control, output latching and radio flag pins.
// Assumes the radio core supplies same-clock pulses and levels; status-line and strap pins other than toggle_select are synchronised here.
`timescale 1ns/1ps
module slrf_status_lines
  import slrf_pkg::*;
#(
  parameter int N = SLRF_LINES
) (
  // Clock, reset and clock enable.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Strapping pins.
  input  wire logic         low_bank_direction,
  input  wire logic         high_bank_direction,
  input  wire logic         toggle_select,
  input  wire logic         ack_reply_enable,
  // Status line pins.
  input  wire logic [N-1:0] status_lines_in,
  output logic      [N-1:0] status_lines_out,
  output logic      [N-1:0] status_lines_oe_n,
  // Radio core side.
  input  wire logic         rf_transmitting,
  input  wire logic         rf_msg_valid,
  input  wire logic [N-1:0] rf_msg_lines,
  input  wire logic         rf_ack_received,
  input  wire logic         rf_control_sent,
  output logic      [N-1:0] rf_input_lines,
  output logic              rf_send_ack,
  // Radio flag pins.
  output logic              transmit_amp_enable,
  output logic              ack_received_ind
);

  // Status-line pin synchroniser and accepted input state.
  logic [N-1:0] line_level;
  logic [N-1:0] in_agree;
  logic [N-1:0] in_d;
  logic [N-1:0] in_q;

  // Strapping pin synchroniser and accepted levels.
  logic [2:0]   dir_pins;
  logic [2:0]   dir_level;
  logic [2:0]   dir_agree;
  logic         low_dir_d;
  logic         low_dir_q;
  logic         high_dir_d;
  logic         high_dir_q;
  logic         ackr_d;
  logic         ackr_q;

  // Output line state.
  logic [N-1:0] is_out;
  logic [N-1:0] toggled;
  logic [N-1:0] momentary;
  logic [N-1:0] out_d;
  logic [N-1:0] out_q;

  // Radio flags.
  logic         pa_d;
  logic         pa_q;
  logic         wait_ack_d;
  logic         wait_ack_q;
  logic         ack_d;
  logic         ack_q;
  logic         send_d;
  logic         send_q;

  // Lines whose bank direction pin reads low are outputs.
  assign is_out[SLRF_LOW_LSB +: SLRF_BANK]  = {SLRF_BANK{~low_dir_q}};
  assign is_out[SLRF_HIGH_LSB +: SLRF_BANK] = {SLRF_BANK{~high_dir_q}};

  // Both banks start as inputs so that no line is driven before the straps are known.
  assign dir_pins   = {ack_reply_enable, high_bank_direction, low_bank_direction};
  assign low_dir_d  = dir_agree[0] ? dir_level[0] : low_dir_q;
  assign high_dir_d = dir_agree[1] ? dir_level[1] : high_dir_q;
  assign ackr_d     = dir_agree[2] ? dir_level[2] : ackr_q;

  // Output lines read back as zero, so their own drive is reported only while the synchroniser still holds it after a bank turns to input.
  assign in_d = ((in_agree & line_level) | (~in_agree & in_q)) & ~is_out;

  // Latched outputs flip on each activation; momentary ones follow valid reception.
  assign toggled   = rf_msg_valid ? (out_q ^ rf_msg_lines) : out_q;
  assign momentary = rf_msg_valid ? rf_msg_lines : {N{1'b0}};
  assign out_d     = (toggle_select ? toggled : momentary) & is_out;

  assign pa_d = rf_transmitting;

  // A new control message rearms the indicator and wins over a reply in the same cycle.
  assign wait_ack_d = rf_control_sent | (wait_ack_q & ~rf_ack_received);
  assign ack_d      = rf_control_sent ? 1'b0 : (ack_q | (wait_ack_q & rf_ack_received));

  assign send_d = ackr_q & rf_msg_valid;

  slrf_sync3 #(
    .W    (N),
    .INIT (N'(SLRF_IN_RESET))
  ) line_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin    (status_lines_in),
    .level  (line_level),
    .agree  (in_agree)
  );

  slrf_sync3 #(
    .W    (3),
    .INIT (SLRF_SYNC_RESET)
  ) strap_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin    (dir_pins),
    .level  (dir_level),
    .agree  (dir_agree)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      in_q <= N'(SLRF_IN_RESET);
    end else if (clk_en) begin
      in_q <= in_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_dir_q  <= SLRF_DIR_RESET;
      high_dir_q <= SLRF_DIR_RESET;
      ackr_q     <= 1'b0;
    end else if (clk_en) begin
      low_dir_q  <= low_dir_d;
      high_dir_q <= high_dir_d;
      ackr_q     <= ackr_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_q <= N'(SLRF_OUT_RESET);
    end else if (clk_en) begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pa_q <= 1'b0;
    end else if (clk_en) begin
      pa_q <= pa_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_ack_q <= 1'b0;
    end else if (clk_en) begin
      wait_ack_q <= wait_ack_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= ack_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      send_q <= 1'b0;
    end else if (clk_en) begin
      send_q <= send_d;
    end
  end

  assign status_lines_out    = out_q;
  assign status_lines_oe_n   = ~is_out;
  assign rf_input_lines      = in_q;
  assign rf_send_ack         = send_q;
  assign transmit_amp_enable = pa_q;
  assign ack_received_ind    = ack_q;

endmodule : slrf_status_lines

// Three-stage pin synchroniser; a level counts once stages two and three agree.
module slrf_sync3
  import slrf_pkg::*;
#(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock, reset and clock enable.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Pin side.
  input  wire logic [W-1:0] pin,
  // Clock side.
  output logic      [W-1:0] level,
  output logic      [W-1:0] agree
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  assign level = s2_q;
  assign agree = s2_q ~^ s3_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else if (clk_en) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

endmodule : slrf_sync3

// [design/slrf_pkg.sv]
// Package for the status-line direction and radio-flag block.
// Assumes a single 125 MHz clock domain with synchronous active-low reset.
package slrf_pkg;
  localparam int          SLRF_LINES      = 8;
  localparam int          SLRF_BANK       = 4;
  localparam int          SLRF_LOW_LSB    = 0;
  localparam int          SLRF_HIGH_LSB   = 4;
  localparam logic [7:0]  SLRF_OUT_RESET  = 8'h00;
  localparam logic [7:0]  SLRF_IN_RESET   = 8'h00;
  localparam logic [2:0]  SLRF_SYNC_RESET = 3'h3;
  localparam int          SLRF_SYNC_DEPTH = 3;
  localparam logic        SLRF_DIR_RESET  = 1'b1;
endpackage : slrf_pkg

// [test/slrf_pins.sv]
// Line model: switches on input lines, loads on output lines.
// Assumes the lines are read back through status_lines_in.
`timescale 1ns/1ps
module slrf_pins (input wire logic [7:0] status_lines_out, status_lines_oe_n, btn,
  output logic [7:0] status_lines_in);
  assign status_lines_in = status_lines_oe_n & btn | ~status_lines_oe_n & status_lines_out;
endmodule : slrf_pins

// [test/slrf_chk.sv]
// Port checker for slrf_status_lines.
// Assumes one clock; bound below.
`timescale 1ns/1ps
module slrf_chk (
  // Clock, reset and clock enable.
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  // Straps.
  input wire logic       low_bank_direction,
  input wire logic       high_bank_direction,
  input wire logic       toggle_select,
  input wire logic       ack_reply_enable,
  // Radio core side.
  input wire logic       rf_transmitting,
  input wire logic       rf_msg_valid,
  input wire logic [7:0] rf_msg_lines,
  input wire logic       rf_ack_received,
  input wire logic       rf_control_sent,
  input wire logic       rf_send_ack,
  // Pins.
  input wire logic [7:0] status_lines_out,
  input wire logic [7:0] status_lines_oe_n,
  input wire logic       transmit_amp_enable,
  input wire logic       ack_received_ind
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  bank_dir_a: assert property ($stable({high_bank_direction, low_bank_direction})[*6] |->
    status_lines_oe_n == {{4{high_bank_direction}}, {4{low_bank_direction}}}) else $error("dir");
  ack_ind_a: assert property (rf_control_sent ##1 (rf_ack_received && !rf_control_sent) |=>
    ack_received_ind) else $error("ack");
  toggle_out_a: assert property (toggle_select && rf_msg_valid && clk_en |=>
    status_lines_out == ($past(status_lines_out) ^ $past(rf_msg_lines) & ~$past(status_lines_oe_n)))
    else $error("toggle");
  momentary_out_a: assert property (!toggle_select && clk_en |=> status_lines_out ==
    (($past(rf_msg_valid) ? $past(rf_msg_lines) : 8'h00) & ~$past(status_lines_oe_n)))
    else $error("momentary");
  reply_req_a: assert property (ack_reply_enable[*6] ##0 rf_msg_valid && clk_en |=> rf_send_ack)
    else $error("reply");
  amp_follow_a: assert property (clk_en |=> transmit_amp_enable == $past(rf_transmitting))
    else $error("amp");
  freeze_hold_a: assert property (!clk_en |=> $stable(status_lines_out) && $stable(transmit_amp_enable))
    else $error("freeze");
  cover property (toggle_select && rf_msg_valid);
  cover property (ack_received_ind);
  cover property (rf_send_ack);
  cover property (!clk_en && rf_transmitting);
endmodule : slrf_chk
bind slrf_status_lines slrf_chk chk (.*);

// [test/tb_top.sv]
// Bench for slrf_status_lines with the line model.
// Assumes an 8 ns mclk; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, rst_n = 0, clk_en = 1, low_bank_direction = 0, high_bank_direction = 0;
  logic toggle_select = 0, ack_reply_enable = 1, rf_transmitting = 0, rf_msg_valid = 0;
  logic rf_ack_received = 0, rf_control_sent = 0, rf_send_ack, transmit_amp_enable;
  logic ack_received_ind;
  logic [7:0] btn = 8'h00, rf_msg_lines = 8'h00, status_lines_in, status_lines_out;
  logic [7:0] status_lines_oe_n, rf_input_lines;
  logic [39:0] rows [3] = '{40'h3FFFF_FF001, 40'hAFFA5_F0050, 40'h4FF3C_00300};
  int bad_count = 0, comparisons = 0;
  always #4 mclk = ~mclk;
  slrf_pins pins (.*);
  slrf_status_lines uut (.*);
  task automatic chk(input string n, input logic [7:0] e, s);
    comparisons++;
    bad_count += int'(s !== e);
    if (s !== e) $display("unexpected %s expected %h seen %h", n, e, s);
  endtask : chk
  task automatic final_report;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    repeat (500) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge mclk);
    chk("oe", 8'hFF, status_lines_oe_n);
    rst_n = 1;
    foreach (rows[i]) begin
      {low_bank_direction, high_bank_direction, rf_msg_valid, rf_transmitting, rf_msg_lines,
        btn} = rows[i][39:20];
      repeat (12) @(negedge mclk);
      chk("out", rows[i][19:12], status_lines_out);
      chk("in", rows[i][11:4], rf_input_lines);
      chk("amp", {4'h0, rows[i][3:0]}, {7'h00, transmit_amp_enable});
    end
    {toggle_select, rf_msg_lines} = 9'h101;
    for (int i = 1; i >= 0; i--) begin
      rf_msg_valid = 1;
      @(negedge mclk) rf_msg_valid = 0;
      chk("out", 8'(i), status_lines_out);
      chk("ack req", 8'h01, {7'h00, rf_send_ack});
      @(negedge mclk);
    end
    rf_control_sent = 1;
    @(negedge mclk) {rf_control_sent, rf_ack_received} = 2'b01;
    @(negedge mclk) rf_ack_received = 0;
    chk("ind", 8'h01, {7'h00, ack_received_ind});
    clk_en = 0;
    rf_transmitting = 1;
    repeat (3) @(negedge mclk);
    chk("amp frozen", 8'h00, {7'h00, transmit_amp_enable});
    clk_en = 1;
    @(negedge mclk) rf_transmitting = 0;
    chk("amp", 8'h01, {7'h00, transmit_amp_enable});
    rst_n = 0;
    @(negedge mclk) chk("oe reset", 8'hFF, status_lines_oe_n);
    chk("ind reset", 8'h00, {7'h00, ack_received_ind});
    rst_n = 1;
    repeat (6) @(negedge mclk);
    chk("oe", 8'hF0, status_lines_oe_n);
    final_report();
  end
endmodule : tb_top
